// [bcfg_decoder.sv]
// startup configuration byte decoder
//
// Summary of operation
// - each of bits 5:0 of the direction byte makes its pin an output when 1, an input when 0.
// - the sampled level of every input pin is reported in the system report data.
// - each output pin drives the level of its bit in the output level byte.
// - a nonzero first name pointer locates a 24-byte name string for the first unit.
// - a nonzero second name pointer locates a 24-byte name string for the second unit.
// - a zero name pointer means the drive's own identify data names the unit.
// - drive access starts only after the programmed number of 20 ms ticks.
// - the bus powered bit marks the first unit fixed while power valid stays in use.
// - the removable UDMA bit connects UDMA signals to the card pins only when 1.
// - the unit count code searches on 00, assumes one unit on 01, two otherwise.
// - bit 0 clear searches the bus on each rise of bus power enable while in run, set skips it.
// - the power valid input is enabled only by bit 0 of the power byte.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module bcfg_decoder #(
	parameter int unsigned TICK_CYCLES = bcfg_pkg::TICK_CYCLES,
	parameter int GPIO_W = bcfg_pkg::GPIO_W
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// configuration memory reader
	output logic EE_REQ,
	output logic [7:0] EE_ADDR,
	input wire logic [7:0] EE_DATA,
	input wire logic EE_ACK,
	// general purpose pins
	input wire logic [GPIO_W-1:0] GPIO_IN,
	output logic [GPIO_W-1:0] GPIO_OUT,
	output logic [GPIO_W-1:0] GPIO_OE,
	output logic [GPIO_W-1:0] SYSTEM_IRQ_REPORT,
	// drive handling
	input wire logic DRIVE_POWER_VALID_IN,
	input wire logic BUS_POWER_ATA_ENABLE,
	output logic DRIVE_ACCESS_EN,
	output logic UNIT_SEARCH_REQ,
	output logic [1:0] UNIT_COUNT,
	output logic UNIT0_BUS_POWERED,
	output logic CARD_UDMA_CONNECT,
	output logic POWER_VALID_EN,
	output logic DRIVE_POWER_OK,
	// identify strings
	output logic UNIT0_NAME_FROM_DRIVE,
	output logic UNIT1_NAME_FROM_DRIVE,
	input wire logic [5:0] NAME_RD_ADDR,
	output logic [7:0] NAME_RD_DATA
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	bcfg_pkg::bcfg_state_t state;
	bcfg_pkg::bcfg_phase_t phase;
	logic [7:0] cfg [bcfg_pkg::CFG_BYTES];
	logic [4:0] cnt;
	logic loaded;
	logic [7:0] ticks_left;
	logic [TW-1:0] tick_cnt;
	logic [GPIO_W+1:0] sync_q;
	logic [GPIO_W-1:0] gpio_s;
	logic dpv_s;
	logic bpe_s;
	logic bpe_d;
	logic reload_req;
	logic rescan_req;
	logic name_we;
	logic [5:0] name_wa;
	logic accept;
	logic enter_run;
	logic restart;
	logic desc_err;
	logic [7:0] unit0_name_pointer;
	logic [7:0] unit1_name_pointer;
	logic [7:0] flags;
	logic [GPIO_W-1:0] dir;
	logic [GPIO_W-1:0] lvl;
	logic removable_udma_allow;
	logic rescan_on_bus_power;
	logic [1:0] unit_count_select;

	function automatic logic [7:0] fetch_addr(input bcfg_pkg::bcfg_phase_t p, input logic [4:0] c,
		input logic [7:0] p0, input logic [7:0] p1);
		logic [7:0] base;
		base = (p == bcfg_pkg::PH_CFG) ? bcfg_pkg::CFG_FIRST_ADDR :
			(p == bcfg_pkg::PH_NAME0) ? p0 : p1;
		return 8'(base + {3'h0, c});
	endfunction : fetch_addr

	function automatic logic last_index(input bcfg_pkg::bcfg_phase_t p, input logic [4:0] c);
		return (p == bcfg_pkg::PH_CFG) ? (c == 5'(bcfg_pkg::CFG_BYTES - 1)) :
			(c == 5'(bcfg_pkg::NAME_LEN - 1));
	endfunction : last_index

	assign gpio_s = sync_q[GPIO_W+1:2];
	assign dpv_s = sync_q[1];
	assign bpe_s = sync_q[0];
	assign unit0_name_pointer = cfg[bcfg_pkg::IDX_PTR0];
	assign unit1_name_pointer = cfg[bcfg_pkg::IDX_PTR1];
	assign flags = cfg[bcfg_pkg::IDX_FLAGS];
	assign dir = cfg[bcfg_pkg::IDX_DIR][GPIO_W-1:0];
	assign lvl = cfg[bcfg_pkg::IDX_LVL][GPIO_W-1:0];
	assign removable_udma_allow = flags[bcfg_pkg::FLAG_UDMA];
	assign rescan_on_bus_power = flags[bcfg_pkg::FLAG_RESCAN];
	assign unit_count_select = flags[bcfg_pkg::FLAG_UNITS_HI:bcfg_pkg::FLAG_UNITS_LO];
	assign accept = (state == bcfg_pkg::ST_WAIT) && EE_ACK;
	assign restart = reload_req && (state == bcfg_pkg::ST_DELAY || state == bcfg_pkg::ST_RUN);
	assign enter_run = (state == bcfg_pkg::ST_DELAY) && !reload_req && (ticks_left == 8'h00);
	assign name_we = accept && (phase != bcfg_pkg::PH_CFG);
	assign name_wa = 6'(((phase == bcfg_pkg::PH_NAME1) ? bcfg_pkg::NAME1_BASE : 6'h00) + {1'b0, cnt});

	// reserved and descriptor bytes checked against their fixed values
	assign desc_err = loaded && ((cfg[bcfg_pkg::IDX_DLEN] != bcfg_pkg::DESC_LEN) ||
		(cfg[bcfg_pkg::IDX_DTYPE] != bcfg_pkg::DESC_TYPE) ||
		(cfg[bcfg_pkg::IDX_RSVD] != bcfg_pkg::RSVD_VALUE) ||
		(cfg[bcfg_pkg::IDX_DIR][7:GPIO_W] != '0) || (cfg[bcfg_pkg::IDX_LVL][7:GPIO_W] != '0));

	bcfg_sync #(
		.W(GPIO_W + 2)
	) u_sync (
		.clk(CLK_SYS),
		.resetn(RESETN),
		.d({GPIO_IN, DRIVE_POWER_VALID_IN, BUS_POWER_ATA_ENABLE}),
		.q(sync_q)
	);

	bcfg_name_mem #(
		.DEPTH(bcfg_pkg::NAME_DEPTH),
		.AW(6)
	) u_names (
		.clk(CLK_SYS),
		.resetn(RESETN),
		.we(name_we),
		.wa(name_wa),
		.wd(EE_DATA),
		.ra(NAME_RD_ADDR),
		.rd(NAME_RD_DATA)
	);

	// fetch sequence, startup delay and run
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state <= bcfg_pkg::ST_FETCH;
			phase <= bcfg_pkg::PH_CFG;
			cnt <= 5'h00;
			EE_REQ <= 1'b0;
			EE_ADDR <= 8'h00;
			loaded <= 1'b0;
			ticks_left <= 8'h00;
			tick_cnt <= '0;
		end else begin
			EE_REQ <= 1'b0;
			unique case (state)
				bcfg_pkg::ST_FETCH: begin
					EE_REQ <= 1'b1;
					EE_ADDR <= fetch_addr(phase, cnt, unit0_name_pointer, unit1_name_pointer);
					state <= bcfg_pkg::ST_WAIT;
				end
				bcfg_pkg::ST_WAIT: begin
					if (EE_ACK && !last_index(phase, cnt)) begin
						cnt <= cnt + 5'h01;
						state <= bcfg_pkg::ST_FETCH;
					end else if (EE_ACK) begin
						cnt <= 5'h00;
						if (phase == bcfg_pkg::PH_CFG && unit0_name_pointer != bcfg_pkg::NAME_NONE) begin
							phase <= bcfg_pkg::PH_NAME0;
							state <= bcfg_pkg::ST_FETCH;
						end else if (phase != bcfg_pkg::PH_NAME1 &&
							unit1_name_pointer != bcfg_pkg::NAME_NONE) begin
							phase <= bcfg_pkg::PH_NAME1;
							state <= bcfg_pkg::ST_FETCH;
						end else begin
							loaded <= 1'b1;
							ticks_left <= cfg[bcfg_pkg::IDX_DELAY];
							tick_cnt <= '0;
							state <= bcfg_pkg::ST_DELAY;
						end
					end
				end
				bcfg_pkg::ST_DELAY: begin
					if (reload_req) begin
						state <= bcfg_pkg::ST_FETCH;
					end else if (ticks_left == 8'h00) begin
						state <= bcfg_pkg::ST_RUN;
					end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
						tick_cnt <= '0;
						ticks_left <= ticks_left - 8'h01;
					end else begin
						tick_cnt <= tick_cnt + TW'(1);
					end
				end
				bcfg_pkg::ST_RUN: begin
					if (reload_req) begin
						state <= bcfg_pkg::ST_FETCH;
					end
				end
			endcase
			if (restart) begin
				phase <= bcfg_pkg::PH_CFG;
				cnt <= 5'h00;
				loaded <= 1'b0;
			end
		end
	end

	// latch of the configuration bytes
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < bcfg_pkg::CFG_BYTES; i++) begin
				cfg[i] <= 8'h00;
			end
		end else if (accept && phase == bcfg_pkg::PH_CFG) begin
			cfg[cnt[3:0]] <= EE_DATA;
		end
	end

	// register port
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			REG_RDATA <= 32'h0000_0000;
			reload_req <= 1'b0;
			rescan_req <= 1'b0;
		end else begin
			reload_req <= REG_WR && (REG_ADDR == bcfg_pkg::REG_CTRL) && REG_WDATA[bcfg_pkg::CTRL_RELOAD];
			rescan_req <= REG_WR && (REG_ADDR == bcfg_pkg::REG_CTRL) && REG_WDATA[bcfg_pkg::CTRL_RESCAN];
			REG_RDATA <= 32'h0000_0000;
			if (REG_RD) begin
				unique case (REG_ADDR)
					bcfg_pkg::REG_STATUS: REG_RDATA <= {28'h000_0000, desc_err, DRIVE_ACCESS_EN,
						(state == bcfg_pkg::ST_DELAY), loaded};
					bcfg_pkg::REG_CFG: REG_RDATA <= {flags, cfg[bcfg_pkg::IDX_DELAY],
						cfg[bcfg_pkg::IDX_LVL], cfg[bcfg_pkg::IDX_DIR]};
					bcfg_pkg::REG_PTR: REG_RDATA <= {cfg[bcfg_pkg::IDX_PWR], 8'h00,
						unit1_name_pointer, unit0_name_pointer};
					bcfg_pkg::REG_GPIO: REG_RDATA <= {26'h000_0000, SYSTEM_IRQ_REPORT};
					default: REG_RDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// pins, only after every byte is latched
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			GPIO_OE <= '0;
			GPIO_OUT <= '0;
			SYSTEM_IRQ_REPORT <= '0;
		end else begin
			GPIO_OE <= loaded ? dir : '0;
			GPIO_OUT <= loaded ? (lvl & dir) : '0;
			SYSTEM_IRQ_REPORT <= loaded ? (gpio_s & ~dir) : '0;
		end
	end

	// drive handling
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			bpe_d <= 1'b0;
			DRIVE_ACCESS_EN <= 1'b0;
			UNIT_SEARCH_REQ <= 1'b0;
			UNIT_COUNT <= 2'h0;
			UNIT0_BUS_POWERED <= 1'b0;
			CARD_UDMA_CONNECT <= 1'b0;
			POWER_VALID_EN <= 1'b0;
			DRIVE_POWER_OK <= 1'b0;
			UNIT0_NAME_FROM_DRIVE <= 1'b0;
			UNIT1_NAME_FROM_DRIVE <= 1'b0;
		end else begin
			bpe_d <= bpe_s;
			// access drops in the cycle a reload leaves run
			DRIVE_ACCESS_EN <= (state == bcfg_pkg::ST_RUN) && !reload_req;
			UNIT_SEARCH_REQ <= (enter_run && unit_count_select == bcfg_pkg::UNITS_SEARCH) ||
				((state == bcfg_pkg::ST_RUN) && !reload_req &&
				((bpe_s && !bpe_d && !rescan_on_bus_power) || rescan_req));
			if (!loaded || unit_count_select == bcfg_pkg::UNITS_SEARCH) begin
				UNIT_COUNT <= 2'h0;
			end else if (unit_count_select == bcfg_pkg::UNITS_ONE) begin
				UNIT_COUNT <= 2'h1;
			end else begin
				UNIT_COUNT <= 2'h2;
			end
			UNIT0_BUS_POWERED <= loaded && flags[bcfg_pkg::FLAG_BUS_POWERED];
			CARD_UDMA_CONNECT <= loaded && removable_udma_allow;
			POWER_VALID_EN <= loaded && cfg[bcfg_pkg::IDX_PWR][bcfg_pkg::PWR_VALID_EN_BIT];
			DRIVE_POWER_OK <= loaded && cfg[bcfg_pkg::IDX_PWR][bcfg_pkg::PWR_VALID_EN_BIT] && dpv_s;
			UNIT0_NAME_FROM_DRIVE <= loaded && (unit0_name_pointer == bcfg_pkg::NAME_NONE);
			UNIT1_NAME_FROM_DRIVE <= loaded && (unit1_name_pointer == bcfg_pkg::NAME_NONE);
		end
	end

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESETN);

	a_pins_held_idle: assert property (!$past(loaded) |-> (GPIO_OE == '0 && GPIO_OUT == '0))
		else $error("pins driven before configuration latched");
	a_dir_to_oe: assert property ($past(loaded) |-> GPIO_OE == $past(dir))
		else $error("pin direction does not follow direction byte");
	a_out_level: assert property ($past(loaded) |-> GPIO_OUT == ($past(lvl) & GPIO_OE))
		else $error("output pin level does not follow level byte");
	a_input_report: assert property ($past(loaded) |->
		SYSTEM_IRQ_REPORT == $past(gpio_s & ~dir))
		else $error("input pin level not reported");
	a_name_fetch: assert property (EE_REQ && $past(phase) == bcfg_pkg::PH_NAME0 |->
		EE_ADDR == 8'($past(unit0_name_pointer) + {3'h0, $past(cnt)}))
		else $error("first unit name fetched from wrong address");
	a_name1_fetch: assert property (EE_REQ && $past(phase) == bcfg_pkg::PH_NAME1 |->
		EE_ADDR == 8'($past(unit1_name_pointer) + {3'h0, $past(cnt)}))
		else $error("second unit name fetched from wrong address");
	a_access_late: assert property (DRIVE_ACCESS_EN |->
		$past(state == bcfg_pkg::ST_RUN) && loaded)
		else $error("drive access before startup delay ended");
	a_delay_hold: assert property (state == bcfg_pkg::ST_DELAY && !reload_req &&
		ticks_left != 8'h00 |=> state == bcfg_pkg::ST_DELAY)
		else $error("startup delay ended early");
	a_one_unit: assert property (loaded && unit_count_select == bcfg_pkg::UNITS_ONE |=>
		UNIT_COUNT == 2'h1)
		else $error("one unit code not applied");
	a_search_entry: assert property (enter_run &&
		unit_count_select == bcfg_pkg::UNITS_SEARCH |=> UNIT_SEARCH_REQ)
		else $error("no search issued for search unit code");
	a_search_skip: assert property (enter_run &&
		unit_count_select != bcfg_pkg::UNITS_SEARCH |=> !UNIT_SEARCH_REQ)
		else $error("search issued for fixed unit count");
	a_rescan_off: assert property (state == bcfg_pkg::ST_RUN && rescan_on_bus_power &&
		!rescan_req |=> !UNIT_SEARCH_REQ)
		else $error("search on bus power while disabled");
	a_bus_powered: assert property ($past(loaded) |->
		UNIT0_BUS_POWERED == $past(flags[bcfg_pkg::FLAG_BUS_POWERED]))
		else $error("bus powered flag not applied");
	a_udma_gate: assert property (CARD_UDMA_CONNECT |->
		$past(loaded && removable_udma_allow))
		else $error("udma connected while not allowed");
	a_power_valid: assert property (DRIVE_POWER_OK |-> POWER_VALID_EN)
		else $error("power valid used while disabled");
	a_name_source: assert property ($past(loaded) |->
		UNIT0_NAME_FROM_DRIVE == ($past(unit0_name_pointer) == bcfg_pkg::NAME_NONE))
		else $error("name source wrong for first unit");

endmodule : bcfg_decoder

// [bcfg_pkg.sv]
// constants and types of the startup configuration byte decoder
package bcfg_pkg;

	// configuration memory layout, bytes 0x08 to 0x11 are fetched in order
	localparam logic [7:0] CFG_FIRST_ADDR = 8'h08;
	localparam int CFG_BYTES = 10;
	localparam int IDX_PWR = 0;
	localparam int IDX_DIR = 1;
	localparam int IDX_LVL = 2;
	localparam int IDX_PTR0 = 3;
	localparam int IDX_PTR1 = 4;
	localparam int IDX_DELAY = 5;
	localparam int IDX_FLAGS = 6;
	localparam int IDX_RSVD = 7;
	localparam int IDX_DLEN = 8;
	localparam int IDX_DTYPE = 9;

	// field positions
	localparam int PWR_VALID_EN_BIT = 0;
	localparam int FLAG_BUS_POWERED = 4;
	localparam int FLAG_UDMA = 3;
	localparam int FLAG_UNITS_HI = 2;
	localparam int FLAG_UNITS_LO = 1;
	localparam int FLAG_RESCAN = 0;
	localparam int GPIO_W = 6;
	localparam logic [1:0] UNITS_SEARCH = 2'h0;
	localparam logic [1:0] UNITS_ONE = 2'h1;

	// expected contents of the fixed bytes
	localparam logic [7:0] RSVD_VALUE = 8'h00;
	localparam logic [7:0] DESC_LEN = 8'h12;
	localparam logic [7:0] DESC_TYPE = 8'h01;
	localparam logic [7:0] NAME_NONE = 8'h00;

	// identify strings
	localparam int NAME_LEN = 24;
	localparam int NAME_DEPTH = 48;
	localparam logic [5:0] NAME1_BASE = 6'h18;

	// startup delay tick
	localparam int TICK_TIME_MS = 20;
	localparam int CLK_FREQ_KHZ = 100_000;
	localparam int TICK_CYCLES = TICK_TIME_MS * CLK_FREQ_KHZ;

	// register port offsets and control bits
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_PTR = 8'h08;
	localparam logic [7:0] REG_GPIO = 8'h0C;
	localparam logic [7:0] REG_CTRL = 8'h10;
	localparam int CTRL_RELOAD = 0;
	localparam int CTRL_RESCAN = 1;

	typedef enum logic [1:0] {ST_FETCH, ST_WAIT, ST_DELAY, ST_RUN} bcfg_state_t;
	typedef enum logic [1:0] {PH_CFG, PH_NAME0, PH_NAME1} bcfg_phase_t;

endpackage : bcfg_pkg

// [bcfg_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module bcfg_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule : bcfg_sync

// [bcfg_name_mem.sv]
// identify string store with registered read
`timescale 1ns/10ps
module bcfg_name_mem #(
	parameter int DEPTH = 48,
	parameter int AW = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// write side
	input wire logic we,
	input wire logic [AW-1:0] wa,
	input wire logic [7:0] wd,
	// read side
	input wire logic [AW-1:0] ra,
	output logic [7:0] rd
);

	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[wa] <= wd;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd <= 8'h00;
		end else begin
			rd <= (int'(ra) < DEPTH) ? mem[ra] : 8'h00;
		end
	end

endmodule : bcfg_name_mem

// [bcfg_eeprom.sv]
// configuration memory model answering byte fetches
`timescale 1ns/10ps
module bcfg_eeprom (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// fetch port
	input wire logic req,
	input wire logic [7:0] addr,
	input wire logic [2:0] lag,
	output logic [7:0] data,
	output logic ack
);
	logic [7:0] mem [256];
	logic [7:0] a;
	logic [2:0] cnt;
	logic busy;
	// one fetch outstanding, answered after lag idle cycles
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack <= 1'h0;
			busy <= 1'h0;
			cnt <= 3'h0;
			a <= 8'h00;
			data <= 8'h00;
		end else begin
			ack <= 1'h0;
			// stale data never looks valid after the answer
			if (ack) begin
				data <= ~data;
			end
			if (req || busy) begin
				if ((req ? lag : cnt) == 3'h0) begin
					ack <= 1'h1;
					busy <= 1'h0;
					data <= mem[req ? addr : a];
				end else begin
					busy <= 1'h1;
					cnt <= (req ? lag : cnt) - 3'h1;
					if (req) begin
						a <= addr;
					end
				end
			end
		end
	end
endmodule : bcfg_eeprom

// [testbench.sv]
// self-checking bench for the configuration byte decoder
`timescale 1ns/10ps
module testbench;
	localparam int TC = 8;
	logic CLK_SYS = 1'h0;
	logic RESETN = 1'h0;
	logic REG_WR = 1'h0, REG_RD = 1'h0, BUS_POWER_ATA_ENABLE = 1'h0;
	logic DRIVE_POWER_VALID_IN = 1'h0, EE_ACK, EE_REQ, DRIVE_ACCESS_EN, UNIT_SEARCH_REQ;
	logic UNIT0_BUS_POWERED, CARD_UDMA_CONNECT, POWER_VALID_EN, DRIVE_POWER_OK;
	logic UNIT0_NAME_FROM_DRIVE, UNIT1_NAME_FROM_DRIVE;
	logic [7:0] REG_ADDR = 8'h00, EE_ADDR, EE_DATA, NAME_RD_DATA;
	logic [31:0] REG_WDATA = 32'h0000_0000, REG_RDATA;
	logic [5:0] GPIO_IN = 6'h00, NAME_RD_ADDR = 6'h00, GPIO_OUT, GPIO_OE, SYSTEM_IRQ_REPORT;
	logic [1:0] UNIT_COUNT;
	logic [2:0] lag = 3'h0;
	logic [7:0] cfg [10];
	int seed = 30, bad_count = 0, samples_checked = 0, cycles = 0;

	bcfg_decoder #(.TICK_CYCLES(TC), .GPIO_W(6)) bcfg_decoder_i (
		.CLK_SYS(CLK_SYS), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EE_REQ(EE_REQ),
		.EE_ADDR(EE_ADDR), .EE_DATA(EE_DATA), .EE_ACK(EE_ACK), .GPIO_IN(GPIO_IN),
		.GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .SYSTEM_IRQ_REPORT(SYSTEM_IRQ_REPORT),
		.DRIVE_POWER_VALID_IN(DRIVE_POWER_VALID_IN), .BUS_POWER_ATA_ENABLE(BUS_POWER_ATA_ENABLE),
		.DRIVE_ACCESS_EN(DRIVE_ACCESS_EN), .UNIT_SEARCH_REQ(UNIT_SEARCH_REQ),
		.UNIT_COUNT(UNIT_COUNT), .UNIT0_BUS_POWERED(UNIT0_BUS_POWERED),
		.CARD_UDMA_CONNECT(CARD_UDMA_CONNECT), .POWER_VALID_EN(POWER_VALID_EN),
		.DRIVE_POWER_OK(DRIVE_POWER_OK), .UNIT0_NAME_FROM_DRIVE(UNIT0_NAME_FROM_DRIVE),
		.UNIT1_NAME_FROM_DRIVE(UNIT1_NAME_FROM_DRIVE), .NAME_RD_ADDR(NAME_RD_ADDR),
		.NAME_RD_DATA(NAME_RD_DATA));

	bcfg_eeprom bcfg_eeprom_i (.clk(CLK_SYS), .resetn(RESETN), .req(EE_REQ), .addr(EE_ADDR),
		.lag(lag), .data(EE_DATA), .ack(EE_ACK));

	always #5 CLK_SYS = ~CLK_SYS;

	// hang guard
	always @(posedge CLK_SYS) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic test_done;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_span(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_span

	function automatic logic [1:0] units_for(input logic [1:0] c);
		return (c == 2'h0) ? 2'h0 : (c == 2'h1) ? 2'h1 : 2'h2;
	endfunction : units_for

	function automatic int fetch_count(input logic [7:0] p0, input logic [7:0] p1);
		return bcfg_pkg::CFG_BYTES + ((p0 != 8'h00) ? bcfg_pkg::NAME_LEN : 0) +
			((p1 != 8'h00) ? bcfg_pkg::NAME_LEN : 0);
	endfunction : fetch_count

	function automatic logic [5:0] in_report(input logic [5:0] pins, input logic [5:0] d);
		return pins & ~d;
	endfunction : in_report

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1'h1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'h0;
	endtask : reg_wr

	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge CLK_SYS);
		REG_RD <= 1'h1;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'h0;
		#1 chk(REG_RDATA, exp);
	endtask : reg_chk

	task automatic name_chk(input logic [5:0] a, input logic [7:0] exp);
		@(posedge CLK_SYS);
		NAME_RD_ADDR <= a;
		@(posedge CLK_SYS);
		#1 chk(NAME_RD_DATA, exp);
	endtask : name_chk

	task automatic watch(input int n, output logic hit);
		hit = 1'h0;
		repeat (n) begin
			@(posedge CLK_SYS);
			#1 if (UNIT_SEARCH_REQ === 1'h1) hit = 1'h1;
		end
	endtask : watch

	// one load of the configuration, then every decoded result
	task automatic run_round(input logic [2:0] r);
		int acks;
		int since;
		logic srch;
		logic hit;
		logic err;
		logic [1:0] code;
		logic [7:0] p;
		for (int i = 0; i < 256; i++) bcfg_eeprom_i.mem[i] = 8'($random(seed));
		cfg[0] = 8'($random(seed));
		cfg[1] = {2'h0, 6'($random(seed))} | 8'h01;
		cfg[2] = {2'h0, 6'($random(seed))};
		cfg[3] = r[0] ? 8'($random(seed)) | 8'h01 : 8'h00;
		cfg[4] = r[1] ? 8'($random(seed)) | 8'h01 : 8'h00;
		cfg[5] = (r == 3'h0) ? 8'h00 : 8'({$random(seed)} % 4);
		cfg[6] = {3'h0, 2'($random(seed)), r[1:0], r[2]};
		cfg[7] = (r == 3'h5) ? 8'h5A : 8'h00;
		cfg[8] = 8'h12;
		cfg[9] = (r == 3'h5) ? 8'h02 : 8'h01;
		for (int i = 0; i < 10; i++) bcfg_eeprom_i.mem[8 + i] = cfg[i];
		err = (r == 3'h5);
		code = cfg[6][2:1];
		@(posedge CLK_SYS);
		GPIO_IN <= 6'($random(seed));
		DRIVE_POWER_VALID_IN <= 1'($random(seed));
		lag <= 3'($random(seed));
		if (r == 3'h0 || r == 3'h6) begin
			RESETN <= 1'h0;
			repeat (12) @(posedge CLK_SYS);
			RESETN <= 1'h1;
		end else begin
			reg_wr(bcfg_pkg::REG_CTRL, 32'h0000_0001);
		end
		acks = 0;
		since = 0;
		srch = 1'h0;
		repeat (3000) begin
			@(posedge CLK_SYS);
			#1 since++;
			if (EE_ACK === 1'h1) begin
				acks++;
				since = 0;
				chk(GPIO_OE, 32'h0000_0000);
				chk(DRIVE_ACCESS_EN, 32'h0000_0000);
			end
			if (acks > 0 && UNIT_SEARCH_REQ === 1'h1) srch = 1'h1;
			if (acks > 0 && DRIVE_ACCESS_EN === 1'h1) break;
		end
		chk(acks, fetch_count(cfg[3], cfg[4]));
		chk_span(since, cfg[5] * TC + 1, cfg[5] * TC + 5);
		chk(GPIO_OE, cfg[1][5:0]);
		chk(GPIO_OUT, cfg[2][5:0] & cfg[1][5:0]);
		chk(SYSTEM_IRQ_REPORT, in_report(GPIO_IN, cfg[1][5:0]));
		chk(UNIT0_BUS_POWERED, cfg[6][4]);
		chk(CARD_UDMA_CONNECT, cfg[6][3]);
		chk(UNIT_COUNT, units_for(code));
		chk(srch, code == 2'h0);
		chk(POWER_VALID_EN, cfg[0][0]);
		chk(DRIVE_POWER_OK, cfg[0][0] & DRIVE_POWER_VALID_IN);
		chk({UNIT1_NAME_FROM_DRIVE, UNIT0_NAME_FROM_DRIVE}, {!r[1], !r[0]});
		for (int i = 0; i < 48; i++) begin
			p = (i < 24) ? cfg[3] : cfg[4];
			if (p != 8'h00) name_chk(6'(i), bcfg_eeprom_i.mem[8'(p + i % 24)]);
		end
		name_chk(6'h3F, 8'h00);
		reg_chk(bcfg_pkg::REG_STATUS, {28'h000_0000, err, 3'h5});
		reg_chk(bcfg_pkg::REG_CFG, {cfg[6], cfg[5], cfg[2], cfg[1]});
		reg_chk(bcfg_pkg::REG_PTR, {cfg[0], 8'h00, cfg[4], cfg[3]});
		reg_chk(bcfg_pkg::REG_GPIO, {26'h000_0000, in_report(GPIO_IN, cfg[1][5:0])});
		reg_chk(8'h20, 32'h0000_0000);
		@(posedge CLK_SYS);
		BUS_POWER_ATA_ENABLE <= 1'h1;
		watch(8, hit);
		chk(hit, !cfg[6][0]);
		@(posedge CLK_SYS);
		BUS_POWER_ATA_ENABLE <= 1'h0;
		watch(6, hit);
		chk(hit, 1'h0);
		reg_wr(bcfg_pkg::REG_CTRL, 32'h0000_0002);
		watch(4, hit);
		chk(hit, 1'h1);
	endtask : run_round

	initial begin
		for (int r = 0; r < 8; r++) run_round(3'(r));
		test_done();
	end
endmodule : testbench
